//--- core/result_rms_trigger_registers.sv
`include "rrt_defs.svh"

// Function
// - Low-result registers show bits 7..0 of the latest channel conversion.
// - High-result registers show the MSB-aligned first eight result bits.
// - Channel 6/7 results sit at 0xac..0xaf and reset to zero.
// - RMS configuration at 0xc0 resets to zero.
// - Configuration bits 7..4 select the RMS input channel.
// - Configuration bit 3 is reserved and always reads zero.
// - Configuration bit 2 enables DC removal from the RMS result.
// - Bits 1..0 select window of 1024, 4096, 16384 or 65536 samples.
// - RMS completes after window length plus 40 further samples.
// - RMS result low byte reads at 0xc1, reset zero.
// - RMS result high byte reads at 0xc2, reset zero.
// - Trigger select bit n lets channel n alerts update output 0.
// - Trigger select at 0xc3 is read/write, resets to 0x02.
module result_rms_trigger_registers
    import rrt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register access from the serial interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Conversion results from the conversion engine
    input wire logic chan6_result_valid,
    input wire logic [11:0] chan6_result,
    input wire logic chan7_result_valid,
    input wire logic [11:0] chan7_result,
    // RMS engine
    input wire logic rms_sample_valid,
    input wire logic rms_result_valid,
    input wire logic [15:0] rms_result,
    output logic [3:0] rms_channel_select,
    output logic dc_removal_enable,
    output logic [1:0] window_length_select,
    output logic [16:0] rms_sample_target,
    output logic rms_complete,
    // Alert flags and output-0 trigger
    input wire logic [7:0] alert_flags,
    output logic [7:0] output0_trigger_select,
    output logic general_output_0_trigger
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    byte_t ch6_low_q, ch6_low_d, ch6_high_q, ch6_high_d;
    byte_t ch7_low_q, ch7_low_d, ch7_high_q, ch7_high_d;
    byte_t cfg_q, cfg_d;
    byte_t rms_low_q, rms_low_d, rms_high_q, rms_high_d;
    byte_t trig_q, trig_d;
    sample_count_t cnt_q, cnt_d;
    logic done_q, done_d;
    byte_t rdata_q, rdata_d;
    logic trig_out_q, trig_out_d;
    sample_count_t target_q, target_d;
    logic cfg_write;

    // Host write strobe for the configuration register
    assign cfg_write = reg_wr && (reg_addr == `ADDR_RMS_CONFIG);

    // ----------------------------------------
    // Channel 6 and 7 last conversion results
    // ----------------------------------------
    // Load on each new result; no host write path reaches these
    always_comb begin
        ch6_low_d = ch6_low_q;
        ch6_high_d = ch6_high_q;
        ch7_low_d = ch7_low_q;
        ch7_high_d = ch7_high_q;
        if (chan6_result_valid) begin
            ch6_low_d = chan6_result[7:0];
            ch6_high_d = chan6_result[11:4];
        end
        if (chan7_result_valid) begin
            ch7_low_d = chan7_result[7:0];
            ch7_high_d = chan7_result[11:4];
        end
    end

    // Result registers, all cleared by reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ch6_low_q <= `RST_RESULT;
            ch6_high_q <= `RST_RESULT;
            ch7_low_q <= `RST_RESULT;
            ch7_high_q <= `RST_RESULT;
        end else begin
            ch6_low_q <= ch6_low_d;
            ch6_high_q <= ch6_high_d;
            ch7_low_q <= ch7_low_d;
            ch7_high_q <= ch7_high_d;
        end
    end

    // ----------------------------------------
    // RMS computation result
    // ----------------------------------------
    // Load both bytes together so they always belong to one result
    always_comb begin
        rms_low_d = rms_low_q;
        rms_high_d = rms_high_q;
        if (rms_result_valid) begin
            rms_low_d = rms_result[7:0];
            rms_high_d = rms_result[15:8];
        end
    end

    // RMS result registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rms_low_q <= `RST_RESULT;
            rms_high_q <= `RST_RESULT;
        end else begin
            rms_low_q <= rms_low_d;
            rms_high_q <= rms_high_d;
        end
    end

    // ----------------------------------------
    // Host-writable configuration and trigger select
    // ----------------------------------------
    // Only writable fields take host data; the reserved bit is masked off
    always_comb begin
        cfg_d = cfg_q;
        trig_d = trig_q;
        if (reg_wr) begin
            unique case (reg_addr)
                `ADDR_RMS_CONFIG: cfg_d = reg_wdata & `CFG_WRITE_MASK;
                `ADDR_OUT0_TRIG_SEL: trig_d = reg_wdata;
                default: ;
            endcase
        end
    end

    // Configuration and trigger select registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= `RST_RMS_CONFIG;
            trig_q <= `RST_OUT0_TRIG_SEL;
        end else begin
            cfg_q <= cfg_d;
            trig_q <= trig_d;
        end
    end

    // ----------------------------------------
    // RMS sample window counter
    // ----------------------------------------
    // Samples to completion follow the window code about to be stored
    always_comb begin
        unique case (window_sel_e'(cfg_d[`CFG_WIN_MSB:`CFG_WIN_LSB]))
            WIN_1K: target_d = `WIN_LEN_0 + `RMS_EXTRA_SAMPLES;
            WIN_4K: target_d = `WIN_LEN_1 + `RMS_EXTRA_SAMPLES;
            WIN_16K: target_d = `WIN_LEN_2 + `RMS_EXTRA_SAMPLES;
            WIN_64K: target_d = `WIN_LEN_3 + `RMS_EXTRA_SAMPLES;
        endcase
    end

    // A config write restarts the window; the pulse marks the last sample
    always_comb begin
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (cfg_write) begin
            cnt_d = '0;
        end else if (rms_sample_valid) begin
            if (cnt_q + 17'd1 >= target_q) begin
                cnt_d = '0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 17'd1;
            end
        end
    end

    // Counter, completion pulse and sample target registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 17'h00000;
            done_q <= 1'b0;
            target_q <= `WIN_LEN_0 + `RMS_EXTRA_SAMPLES;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
            target_q <= target_d;
        end
    end

    // ----------------------------------------
    // Output-0 trigger
    // ----------------------------------------
    // Any alert on a selected channel requests an update of output 0
    always_comb begin
        trig_out_d = |(alert_flags & trig_q);
    end

    // Trigger request register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trig_out_q <= 1'b0;
        end else begin
            trig_out_q <= trig_out_d;
        end
    end

    // ----------------------------------------
    // Register read path
    // ----------------------------------------
    // Address decode for reads; unmapped addresses read zero
    always_comb begin
        unique case (reg_addr)
            `ADDR_CH6_RESULT_LOW: rdata_d = ch6_low_q;
            `ADDR_CH6_RESULT_HIGH: rdata_d = ch6_high_q;
            `ADDR_CH7_RESULT_LOW: rdata_d = ch7_low_q;
            `ADDR_CH7_RESULT_HIGH: rdata_d = ch7_high_q;
            `ADDR_RMS_CONFIG: rdata_d = cfg_q & `CFG_WRITE_MASK;
            `ADDR_RMS_RESULT_LOW: rdata_d = rms_low_q;
            `ADDR_RMS_RESULT_HIGH: rdata_d = rms_high_q;
            `ADDR_OUT0_TRIG_SEL: rdata_d = trig_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data register; answers one cycle after the address
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs
    assign reg_rdata = rdata_q;
    assign rms_channel_select = cfg_q[`CFG_CHAN_MSB:`CFG_CHAN_LSB];
    assign dc_removal_enable = cfg_q[`CFG_DC_BIT];
    assign window_length_select = cfg_q[`CFG_WIN_MSB:`CFG_WIN_LSB];
    assign rms_sample_target = target_q;
    assign rms_complete = done_q;
    assign output0_trigger_select = trig_q;
    assign general_output_0_trigger = trig_out_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_rsvd_reads_zero: assert property (@(posedge clk) disable iff (!arst_n)
        ##1 ($past(reg_addr) == `ADDR_RMS_CONFIG) |-> reg_rdata[3] == 1'b0)
        else $error("reserved config bit read nonzero");
    a_cfg_write_takes: assert property (@(posedge clk) disable iff (!arst_n)
        reg_wr && reg_addr == `ADDR_RMS_CONFIG |=> rms_channel_select == $past(reg_wdata[7:4]))
        else $error("channel select not written");
    a_dc_write_takes: assert property (@(posedge clk) disable iff (!arst_n)
        reg_wr && reg_addr == `ADDR_RMS_CONFIG |=> dc_removal_enable == $past(reg_wdata[2]))
        else $error("dc removal not written");
    a_win_target: assert property (@(posedge clk) disable iff (!arst_n)
        window_length_select == 2'b01 |-> rms_sample_target == 17'd4136)
        else $error("window target wrong");
    a_rms_low_read: assert property (@(posedge clk) disable iff (!arst_n)
        rms_result_valid ##1 (reg_addr == `ADDR_RMS_RESULT_LOW && !rms_result_valid)
        |=> reg_rdata == $past(rms_result[7:0], 2))
        else $error("rms low byte mismatch");
    a_rms_high_read: assert property (@(posedge clk) disable iff (!arst_n)
        rms_result_valid ##1 (reg_addr == `ADDR_RMS_RESULT_HIGH && !rms_result_valid)
        |=> reg_rdata == $past(rms_result[15:8], 2))
        else $error("rms high byte mismatch");
    a_trig_gate: assert property (@(posedge clk) disable iff (!arst_n)
        |(alert_flags & output0_trigger_select) |=> general_output_0_trigger)
        else $error("trigger not raised");
    a_ro_write_ignored: assert property (@(posedge clk) disable iff (!arst_n)
        reg_wr && reg_addr == `ADDR_RMS_RESULT_HIGH && !rms_result_valid
        |=> $stable(rms_high_q))
        else $error("read-only register changed by write");
    a_ch6_high: assert property (@(posedge clk) disable iff (!arst_n)
        chan6_result_valid |=> ch6_high_q == $past(chan6_result[11:4]))
        else $error("channel 6 high byte wrong");
    a_ch7_low: assert property (@(posedge clk) disable iff (!arst_n)
        chan7_result_valid |=> ch7_low_q == $past(chan7_result[7:0]))
        else $error("channel 7 low byte wrong");
    a_trig_quiet: assert property (@(posedge clk) disable iff (!arst_n)
        !(|(alert_flags & output0_trigger_select)) |=> !general_output_0_trigger)
        else $error("trigger raised without selected alert");
    a_trig_write_takes: assert property (@(posedge clk) disable iff (!arst_n)
        reg_wr && reg_addr == `ADDR_OUT0_TRIG_SEL |=> output0_trigger_select == $past(reg_wdata))
        else $error("trigger select not written");
    a_rsvd_dropped: assert property (@(posedge clk) disable iff (!arst_n)
        cfg_write |=> cfg_q[`CFG_RSVD_BIT] == 1'b0)
        else $error("reserved config bit stored");
    a_count_restart: assert property (@(posedge clk) disable iff (!arst_n)
        cfg_write |=> cnt_q == 17'h00000)
        else $error("window count not restarted");
    a_done_single: assert property (@(posedge clk) disable iff (!arst_n)
        rms_complete |=> !rms_complete)
        else $error("completion pulse too long");
    a_win_longest: assert property (@(posedge clk) disable iff (!arst_n)
        window_length_select == 2'b11 |-> rms_sample_target == 17'd65576)
        else $error("longest window target wrong");
    c_cfg_write: cover property (@(posedge clk) disable iff (!arst_n)
        reg_wr && reg_addr == `ADDR_RMS_CONFIG);
    c_trig_select_write: cover property (@(posedge clk) disable iff (!arst_n)
        reg_wr && reg_addr == `ADDR_OUT0_TRIG_SEL);
    c_rms_done: cover property (@(posedge clk) disable iff (!arst_n) rms_complete);
    c_trigger: cover property (@(posedge clk) disable iff (!arst_n) general_output_0_trigger);

endmodule

//--- core/rrt_defs.svh
`ifndef RRT_DEFS_SVH
`define RRT_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CH6_RESULT_LOW 8'hac
`define ADDR_CH6_RESULT_HIGH 8'had
`define ADDR_CH7_RESULT_LOW 8'hae
`define ADDR_CH7_RESULT_HIGH 8'haf
`define ADDR_RMS_CONFIG 8'hc0
`define ADDR_RMS_RESULT_LOW 8'hc1
`define ADDR_RMS_RESULT_HIGH 8'hc2
`define ADDR_OUT0_TRIG_SEL 8'hc3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_RESULT 8'h00
`define RST_RMS_CONFIG 8'h00
`define RST_OUT0_TRIG_SEL 8'h02

// ----------------------------------------
// Configuration field positions
// ----------------------------------------
`define CFG_CHAN_MSB 7
`define CFG_CHAN_LSB 4
`define CFG_RSVD_BIT 3
`define CFG_DC_BIT 2
`define CFG_WIN_MSB 1
`define CFG_WIN_LSB 0
`define CFG_WRITE_MASK 8'hf7

// ----------------------------------------
// Window lengths in samples, and the extra samples to finish
// ----------------------------------------
`define WIN_LEN_0 17'd1024
`define WIN_LEN_1 17'd4096
`define WIN_LEN_2 17'd16384
`define WIN_LEN_3 17'd65536
`define RMS_EXTRA_SAMPLES 17'd40

`endif

//--- core/rrt_pkg.sv
package rrt_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [16:0] sample_count_t;
    // Window length selection codes
    typedef enum logic [1:0] {
        WIN_1K = 2'b00,
        WIN_4K = 2'b01,
        WIN_16K = 2'b10,
        WIN_64K = 2'b11
    } window_sel_e;
endpackage

//--- tb/host_model.sv
module host_model (
    // Clock
    input wire logic clk,
    // Register access
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Host side of the register interface
    // ----------------------------------------
    // Idle values at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    // One strobe cycle; data scrambled once the write is taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        #1;
    endtask
    // Data answers one cycle after the address is seen
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule

//--- tb/result_rms_trigger_registers_bench.sv
`include "rrt_defs.svh"

module result_rms_trigger_registers_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, arst_n, reg_wr, c6v, c7v, smp_v, rms_v, rc, trig;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, alerts, tsel, d;
    logic [11:0] c6, c7;
    logic [15:0] rms;
    logic [3:0] chan;
    logic dc;
    logic [1:0] win;
    logic [16:0] target;
    int fails, tests_run, cycles, i, n;
    logic [7:0] addrs [8] = '{8'hac, 8'had, 8'hae, 8'haf, 8'hc0, 8'hc1, 8'hc2, 8'hc3};
    logic [7:0] res [6] = '{8'hbc, 8'hab, 8'ha3, 8'h5a, 8'h34, 8'h12};

    // Device under test and host
    result_rms_trigger_registers result_rms_trigger_registers_i (.clk(clk), .arst_n(arst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .chan6_result_valid(c6v), .chan6_result(c6), .chan7_result_valid(c7v),
        .chan7_result(c7), .rms_sample_valid(smp_v), .rms_result_valid(rms_v),
        .rms_result(rms), .rms_channel_select(chan), .dc_removal_enable(dc),
        .window_length_select(win), .rms_sample_target(target), .rms_complete(rc),
        .alert_flags(alerts), .output0_trigger_select(tsel),
        .general_output_0_trigger(trig));
    host_model host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // ----------------------------------------
    // Clock, timeout and reporting
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    // Compare one value
    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Verdict and end of run
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Every register at its reset value
    task automatic t_reset();
        for (i = 0; i < 8; i++) begin
            host_model_i.rd(addrs[i], d);
            chk(d, (i == 7) ? 8'h02 : 8'h00);
        end
        chk(target, 17'd1064);
        chk(tsel, 8'h02);
        $display("reset values done");
    endtask
    // Config fields, reserved bit and all window codes
    task automatic t_config();
        host_model_i.wr(`ADDR_RMS_CONFIG, 8'hff);
        chk({chan, dc, win}, 7'h7f);
        host_model_i.rd(`ADDR_RMS_CONFIG, d);
        chk(d, 8'hf7);
        for (i = 0; i < 4; i++) begin
            host_model_i.wr(`ADDR_RMS_CONFIG, {4'h5, 2'b00, i[1:0]} | {5'h00, i[0], 2'b00});
            chk(target, (17'd1024 << (2 * i)) + 17'd40);
            chk({chan, dc}, {4'h5, i[0]});
        end
        host_model_i.wr(`ADDR_RMS_CONFIG, 8'h00);
        @(posedge clk);
        smp_v <= 1'b1;
        for (n = 0; n < 1200 && rc !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(n, 17'd1064);
        @(posedge clk);
        smp_v <= 1'b0;
        #1;
        chk(rc, 1'b0);
        $display("config done");
    endtask
    // Result capture, byte layout and ignored writes
    task automatic t_results();
        @(posedge clk);
        {c6v, c7v, rms_v} <= 3'b111;
        {c6, c7, rms} <= {12'habc, 12'h5a3, 16'h1234};
        @(posedge clk);
        {c6v, c7v, rms_v} <= 3'b000;
        {c6, c7, rms} <= '1;
        host_model_i.wr(`ADDR_CH6_RESULT_LOW, 8'hff);
        host_model_i.wr(`ADDR_RMS_RESULT_LOW, 8'hff);
        for (i = 0; i < 6; i++) begin
            host_model_i.rd(addrs[i < 4 ? i : i + 1], d);
            chk(d, res[i]);
        end
        $display("results done");
    endtask
    // Trigger select per-channel enables
    task automatic t_trigger();
        host_model_i.wr(`ADDR_OUT0_TRIG_SEL, 8'h81);
        host_model_i.rd(`ADDR_OUT0_TRIG_SEL, d);
        chk(d, 8'h81);
        chk(tsel, 8'h81);
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            alerts <= 8'h01 << i;
            repeat (2) @(posedge clk);
            #1;
            chk(trig, (i == 0 || i == 7));
        end
        $display("trigger done");
    endtask

    // Mid-run reset returns written registers to their reset values
    task automatic t_rereset();
        host_model_i.wr(`ADDR_RMS_CONFIG, 8'h35);
        chk(target, 17'd4136);
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        host_model_i.rd(`ADDR_OUT0_TRIG_SEL, d);
        chk(d, 8'h02);
        host_model_i.rd(`ADDR_RMS_CONFIG, d);
        chk(d, 8'h00);
        host_model_i.rd(`ADDR_CH6_RESULT_HIGH, d);
        chk(d, 8'h00);
        chk({tsel, trig}, {8'h02, 1'b0});
        chk(target, 17'd1064);
        $display("mid-run reset done");
    endtask

    // Main sequence
    initial begin
        {arst_n, c6v, c7v, smp_v, rms_v} = '0;
        {c6, c7, rms, alerts} = '0;
        {fails, tests_run, cycles} = '0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_config();
        t_results();
        t_trigger();
        t_rereset();
        summarize();
    end
endmodule
